// File: logic/wwdg_defines.vh
// offsets, field positions, reset values and timing counts of the window watchdog
`ifndef WWDG_DEFINES_VH
`define WWDG_DEFINES_VH
`define WWDG_OFF_CONTROL 12'h000
`define WWDG_OFF_CONFIG 12'h004
`define WWDG_OFF_STATUS 12'h008
`define WWDG_OFF_IRQ_ENABLE 12'h00C
`define WWDG_OFF_IRQ_CLEAR 12'h010
`define WWDG_CTL_ACTIVATE 7
`define WWDG_CFG_DIV_LO 7
`define WWDG_CFG_DIV_HI 8
`define WWDG_CFG_EWIE 9
`define WWDG_RST_COUNTER 7'h7F
`define WWDG_RST_WINDOW 7'h7F
`define WWDG_WARN_VALUE 7'h40
`define WWDG_BASE_DIV 4096
`define WWDG_RESET_PULSE 4'h8
`endif

// File: logic/wwdg_top.v
// window watchdog with apb register access, early warning flag and interrupt
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "wwdg_defines.vh"

// Contract
// - down counter is 7 bits in control[6:0], reset value 0x7F
// - watchdog reset fires when counter decrements from 0x40 to 0x3F
// - activate bit 7 set by software write, cleared only by reset
// - no watchdog reset while activate bit is zero
// - config[6:0] holds window value, reset 0x7F, compared with counter
// - tick is clock/4096 then /1,/2,/4,/8 by config[8:7]
// - early warning irq enable bit 9 raises irq at 0x40, reset-only clear; irq also needs irq enable register bit 0, reset 1
// - early warning flag status bit 0 set at 0x40 regardless of enable
// - writing zero clears the flag, writing one leaves it unchanged
// - halfword and word accesses are accepted on all registers
module wwdg_top #(
   parameter BASE_DIV = `WWDG_BASE_DIV
)(
   input wire mclk,
   input wire srst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg wdog_reset,
   output reg irq
);

   reg [6:0] down_counter_value_q;
   reg watchdog_activate_q;
   reg [6:0] window_value_q;
   reg [1:0] tick_divider_select_q;
   reg early_warning_irq_enable_q;
   reg early_warning_flag_q;
   reg irq_en_q;
   reg [12:0] base_cnt_q;
   reg [2:0] div_cnt_q;
   reg [3:0] rst_cnt_q;
   reg access_q;
   wire wr;
   wire rd;
   wire low_lanes;
   wire base_tick;
   wire tick;
   wire warn_hit;
   wire underflow;
   wire ctl_wr;
   wire late_reload;
   // last prescaler count, cut to the counter's width on purpose
   localparam [31:0] BASE_LAST_W = BASE_DIV - 1;
   localparam [12:0] BASE_LAST = BASE_LAST_W[12:0];

   // decode of a byte address onto one of the five words
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr[11:2] == off[11:2]);
      end
   endfunction

   // a write lands only at the edge that completes the transfer
   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && penable && !pwrite && !access_q;
   // all fields sit in the low halfword, so any strobe touching it counts
   assign low_lanes = pstrb[0] || pstrb[1];
   assign ctl_wr = wr && low_lanes && hit(paddr, `WWDG_OFF_CONTROL);

   // base divider of 4096 and the selectable extra divider
   assign base_tick = (base_cnt_q == BASE_LAST);
   assign tick = base_tick && ((div_cnt_q & ((3'b001 << tick_divider_select_q) - 3'b001)) == 3'b000);
   assign warn_hit = tick && (down_counter_value_q == `WWDG_WARN_VALUE + 7'h01);
   assign underflow = tick && (down_counter_value_q == `WWDG_WARN_VALUE);
   // reload while counter still above window is too early
   assign late_reload = ctl_wr && (down_counter_value_q > window_value_q);

   // prescaler chain
   always @(posedge mclk)
   begin
      if (srst)
      begin
         base_cnt_q <= 13'h0000;
         div_cnt_q <= 3'h0;
      end
      else if (base_tick)
      begin
         base_cnt_q <= 13'h0000;
         div_cnt_q <= div_cnt_q + 3'h1;
      end
      else
         base_cnt_q <= base_cnt_q + 13'h0001;
   end

   // counter, activate bit, window and config
   always @(posedge mclk)
   begin
      if (srst)
      begin
         down_counter_value_q <= `WWDG_RST_COUNTER;
         watchdog_activate_q <= 1'b0;
         window_value_q <= `WWDG_RST_WINDOW;
         tick_divider_select_q <= 2'b00;
         early_warning_irq_enable_q <= 1'b0;
      end
      else
      begin
         if (ctl_wr)
         begin
            down_counter_value_q <= pwdata[6:0];
            if (pwdata[`WWDG_CTL_ACTIVATE])
               watchdog_activate_q <= 1'b1;
         end
         else if (tick)
            down_counter_value_q <= down_counter_value_q - 7'h01;
         if (wr && low_lanes && hit(paddr, `WWDG_OFF_CONFIG))
         begin
            window_value_q <= pwdata[6:0];
            tick_divider_select_q <= pwdata[`WWDG_CFG_DIV_HI:`WWDG_CFG_DIV_LO];
            // set only; a zero write cannot clear it
            if (pwdata[`WWDG_CFG_EWIE])
               early_warning_irq_enable_q <= 1'b1;
         end
      end
   end

   // early warning flag: hardware set wins over a software clear
   always @(posedge mclk)
   begin
      if (srst)
         early_warning_flag_q <= 1'b0;
      else if (warn_hit)
         early_warning_flag_q <= 1'b1;
      else if (wr && pstrb[0] && hit(paddr, `WWDG_OFF_STATUS) && !pwdata[0])
         early_warning_flag_q <= 1'b0;
      else if (wr && pstrb[0] && hit(paddr, `WWDG_OFF_IRQ_CLEAR) && pwdata[0])
         early_warning_flag_q <= 1'b0;
   end

   // interrupt enable of the status layout; irq needs both enables
   always @(posedge mclk)
   begin
      if (srst)
      begin
         irq_en_q <= 1'b1;
         irq <= 1'b0;
      end
      else
      begin
         if (wr && pstrb[0] && hit(paddr, `WWDG_OFF_IRQ_ENABLE))
            irq_en_q <= pwdata[0];
         irq <= early_warning_flag_q && early_warning_irq_enable_q && irq_en_q;
      end
   end

   // reset pulse, held a few cycles so the system sees it
   always @(posedge mclk)
   begin
      if (srst)
      begin
         rst_cnt_q <= 4'h0;
         wdog_reset <= 1'b0;
      end
      else
      begin
         if (watchdog_activate_q && (underflow || late_reload))
            rst_cnt_q <= `WWDG_RESET_PULSE;
         else if (rst_cnt_q != 4'h0)
            rst_cnt_q <= rst_cnt_q - 4'h1;
         wdog_reset <= watchdog_activate_q && (underflow || late_reload || rst_cnt_q != 4'h0);
      end
   end

   // apb answer: one wait state, then a one-cycle ready; error on unmapped word
   always @(posedge mclk)
   begin
      if (srst)
      begin
         access_q <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         access_q <= psel && penable && !access_q;
         pready <= psel && penable && !access_q;
         pslverr <= 1'b0;
         if (psel && penable && !access_q)
         begin
            prdata <= 32'h0000_0000;
            if (!(hit(paddr, `WWDG_OFF_CONTROL) || hit(paddr, `WWDG_OFF_CONFIG) ||
               hit(paddr, `WWDG_OFF_STATUS) || hit(paddr, `WWDG_OFF_IRQ_ENABLE) ||
               hit(paddr, `WWDG_OFF_IRQ_CLEAR)))
               pslverr <= 1'b1;
            else if (rd && hit(paddr, `WWDG_OFF_CONTROL))
               prdata <= {24'h00_0000, watchdog_activate_q, down_counter_value_q};
            else if (rd && hit(paddr, `WWDG_OFF_CONFIG))
               prdata <= {22'h0_0000, early_warning_irq_enable_q, tick_divider_select_q, window_value_q};
            else if (rd && hit(paddr, `WWDG_OFF_STATUS))
               prdata <= {31'h000_0000, early_warning_flag_q};
            else if (rd && hit(paddr, `WWDG_OFF_IRQ_ENABLE))
               prdata <= {31'h000_0000, irq_en_q};
         end
      end
   end

endmodule

// File: testbench/wwdg_properties.sv
// port assertions for the window watchdog
`timescale 1ns/1ps
module wwdg_properties(
   input wire logic mclk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wdog_reset,
   input wire logic irq
);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
// an access taken but not yet answered
sequence s_wait;
   psel && penable && !pready;
endsequence
AST_RDY_ONE: assert property (s_wait |=> pready) else $error("no answer");
AST_RDY_CAUSE: assert property ($rose(pready) |-> $past(psel && penable)) else $error("stray ready");
AST_RDY_PULSE: assert property (pready |=> !pready) else $error("long ready");
AST_ERR_BAD: assert property (pready && paddr[11:2] > 4 |-> pslverr) else $error("no error");
AST_ERR_OK: assert property (pready && paddr[11:2] < 5 |-> !pslverr) else $error("bad error");
AST_RD_HOLD: assert property (!pready |-> $stable(prdata)) else $error("data moved");
AST_RST_LEN: assert property ($rose(wdog_reset) |=> wdog_reset[*7]) else $error("short reset");
// a write lands at the ready edge, the flag drops there, irq one edge later
AST_IRQ_DROP: assert property ($fell(irq) && !$past(srst) |-> $past(psel && pwrite && pready, 2))
   else $error("irq dropped");
endmodule
bind wwdg_top wwdg_properties chk_u(.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .wdog_reset, .irq);

// File: testbench/test_wwdg_top.sv
// self-checking bench for the window watchdog
`timescale 1ns/1ps
module test_wwdg_top;
logic mclk, srst, psel, penable, pwrite, er, pready, pslverr, wdog_reset, irq;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, r, s;
logic [3:0] pstrb;
int num_errors, total_checks, n;
// short base divider keeps the run brief
wwdg_top #(.BASE_DIV(16)) dut_u(.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .wdog_reset, .irq);
initial
begin
   mclk = 0;
   forever #12.5 mclk = ~mclk;
end
function logic [31:0] lf(input logic [31:0] x);
   return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
// expected tick period for a divider code
function int tp(input int d);
   return 16 << d;
endfunction
task chk(input logic [31:0] g, e);
   total_checks++;
   if (g !== e)
   begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
   end
endtask
// one apb transfer, held until ready
task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
   @(posedge mclk);
   psel <= 1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge mclk);
   penable <= 1;
   // no cycle count assumed; only the bench timeout ends a hung wait
   do
      @(posedge mclk);
   while (pready !== 1'b1);
   r = prdata;
   er = pslverr;
   psel <= 0;
   penable <= 0;
endtask
// bounded wait on irq or watchdog reset
task automatic wf(input bit i);
   n = 0;
   while ((i ? wdog_reset : irq) !== 1'b1 && n < 600)
   begin
      @(posedge mclk);
      n++;
   end
endtask
task stop_test;
   $display("checks %0d errors %0d", total_checks, num_errors);
   if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
endtask
initial
begin
   {psel, penable, pwrite, paddr, pwdata} = '0;
   pstrb = 4'hf;
   srst = 1;
   s = 32'h78a0_5c0b;
   repeat (10) @(posedge mclk);
   srst <= 0;
   ap(0, 0, 0);
   chk(r, 32'h0000_007f);
   ap(0, 4, 0);
   chk(r, 32'h0000_007f);
   ap(0, 12'h014, 0);
   chk(er, 1);
   $display("test reset values done");
   // random loads; at most one tick between write and read
   repeat (8)
   begin
      s = lf(s);
      ap(1, 0, {25'h0, s[6:0]});
      ap(0, 0, 0);
      chk(7'(s[6:0] - r[6:0]) < 2, 1);
   end
   // halfword strobes land, upper-lane-only strobes are ignored
   pstrb <= 4'h3;
   ap(1, 0, 32'h20);
   pstrb <= 4'hc;
   ap(1, 0, 32'h10);
   pstrb <= 4'hf;
   ap(0, 0, 0);
   chk(7'(7'h20 - r[6:0]) < 3, 1);
   $display("test counter loads done");
   // inactive watchdog crosses 0x40: flag set, but no reset in the whole wait
   ap(1, 0, 32'h41);
   wf(1);
   chk(n, 600);
   chk(wdog_reset, 0);
   ap(0, 8, 0);
   chk(r, 1);
   ap(1, 8, 1);
   ap(0, 8, 0);
   chk(r, 1);
   ap(1, 8, 0);
   ap(0, 8, 0);
   chk(r, 0);
   $display("test early warning flag done");
   // every divider code, two ticks to the warning
   for (int d = 0; d < 4; d++)
   begin
      ap(1, 4, {22'h0, 1'b1, d[1:0], 7'h7f});
      ap(1, 0, 32'h42);
      wf(0);
      chk(n >= tp(d) && n <= 2 * tp(d) + 6, 1);
      ap(1, d[0] ? 12'h010 : 12'h008, {31'h0, d[0]});
      // flag drops at the ready edge, irq follows one edge later
      repeat (2) @(posedge mclk);
      chk(irq, 0);
   end
   $display("test dividers done");
   ap(1, 12'h00c, 0);
   ap(1, 0, 32'hc1);
   wf(1);
   chk(n >= tp(3) && n <= 2 * tp(3) + 6, 1);
   chk(irq, 0);
   ap(1, 0, 32'h7f);
   ap(0, 0, 0);
   chk(r[7], 1);
   ap(1, 4, 32'h0000_0250);
   ap(1, 0, 32'hff);
   wf(1);
   chk(n < 4, 1);
   $display("test watchdog resets done");
   srst <= 1;
   @(posedge mclk);
   srst <= 0;
   ap(0, 0, 0);
   chk(r, 32'h0000_007f);
   $display("test mid-run reset done");
   stop_test;
end
initial
begin
   repeat (20000) @(posedge mclk);
   num_errors++;
   stop_test;
end
endmodule
